/* File: include/bstap_pkg.sv */
`default_nettype none
package bstap_pkg;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bstap_state_t;

  localparam int          IR_W        = 8;
  localparam int          BCELL_W     = 48;
  localparam int          RUNSEL_W    = 3;
  localparam int          ID_W        = 32;
  localparam int          OE_CELL_HI  = 47;
  localparam int          OE_CELL_LO  = 44;
  localparam logic [7:0]  IR_RESET    = 8'h81;
  localparam logic [7:0]  IR_CAPTURE  = 8'h81;
  localparam logic [2:0]  RUNSEL_RESET = 3'h2;
  // Identity value is arbitrary, not a real maker code
  localparam logic [31:0] ID_VALUE    = 32'h0000_0001;

  // Opcode low bits; bit 7 is even parity
  localparam logic [6:0]  OP_EXTEST   = 7'h00;
  localparam logic [6:0]  OP_IDCODE   = 7'h01;
  localparam logic [6:0]  OP_SAMPLE   = 7'h02;
  localparam logic [6:0]  OP_RUNT     = 7'h09;
  localparam logic [6:0]  OP_SCANCTL  = 7'h0A;
  localparam logic [6:0]  OP_BYPASS   = 7'h7F;

  typedef enum logic [1:0] { DR_BYPASS, DR_BCELL, DR_RUNSEL, DR_IDENT } bstap_dr_t;

  typedef struct packed {
    logic       testMode;
    logic       runTest;
    bstap_dr_t  drSel;
  } bstap_decode_t;
endpackage : bstap_pkg
`default_nettype wire

/* File: rtl/bstap_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module bstap_decode (
  input  wire logic [7:0]              opcode,  // Current instruction
  output var bstap_pkg::bstap_decode_t dec      // Decoded controls
);
  import bstap_pkg::*;
  logic parityOk;
  always_comb begin
    parityOk = ~^opcode;
    dec.testMode = 1'b0;
    dec.runTest  = 1'b0;
    dec.drSel    = DR_BYPASS;
    // Bad parity or unknown opcode falls to bypass
    if (parityOk) begin
      case (opcode[6:0])
        OP_EXTEST: begin
          dec.testMode = 1'b1;
          dec.drSel    = DR_BCELL;
        end
        OP_IDCODE:  dec.drSel = DR_IDENT;
        OP_SAMPLE:  dec.drSel = DR_BCELL;
        OP_RUNT: begin
          dec.testMode = 1'b1;
          dec.runTest  = 1'b1;
          dec.drSel    = DR_BCELL;
        end
        OP_SCANCTL: dec.drSel = DR_RUNSEL;
        default:    dec.drSel = DR_BYPASS;
      endcase
    end
  end
endmodule : bstap_decode
`default_nettype wire

/* File: rtl/bstap_tap.sv */
// Function
// - Sixteen states advanced by TMS on rising TCK
// - Power-up enters logic reset, normal function
// - TMS high five clocks reaches reset
// - Instruction resets to 10000001 IDCODE
// - Boundary cells 47..44 reset to one
// - Run-test selector resets to 010
// - Run-test operations only in idle state
// - Select states do nothing, left next cycle
// - Data capture loads on exiting edge
// - Shift entry enables TDO on falling edge
// - One shift per clock, none on entry
// - Exit-1 floats TDO on falling edge
// - Pause keeps contents, no recapture
// - Data update latches on falling edge
// - Instruction capture loads 10000001
// - Instruction update latches on falling edge
// - Shadow latches except bypass and identity
// - Eight-bit instruction selects mode and register
// - Even parity opcodes, bit 7 parity
// - Unknown opcodes act as bypass
// - Only one register in the scan path
// - Sample on rise, outputs change on fall
// - Bypass captures zero
// - Selector unchanged during data capture
// - Test mode inhibits normal transceiver function
`timescale 1ns/100ps
`default_nettype none
module bstap_tap (
  input  wire logic                     mclk,           // 50 MHz system clock
  input  wire logic                     sys_rst,        // Sync reset, high
  input  wire logic                     tck,            // Test clock pin
  input  wire logic                     tms,            // Test mode select pin
  input  wire logic                     tdi,            // Test data in pin
  output logic                          tdoOut,         // Test data out level
  output logic                          tdoOe,          // TDO drive enable
  input  wire logic [47:0]              bcellCapture,   // Boundary capture source
  output logic      [47:0]              boundaryCellChain, // Boundary shadow latches
  output logic      [2:0]               runTestOpSelector, // Run-test op select
  output logic      [7:0]               instructionLatch,  // Current instruction
  output logic                          testMode,       // Transceiver inhibited
  output logic                          runTestActive,  // Run-test op running
  output var bstap_pkg::bstap_state_t   tapState        // Controller state
);
  import bstap_pkg::*;

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [2:0] tckSync_q, tckSync_d;
  logic [1:0] tmsSync_q, tmsSync_d, tdiSync_q, tdiSync_d;
  logic       tckRise, tckFall;
  always_comb begin
    tckSync_d = {tckSync_q[1:0], tck};
    tmsSync_d = {tmsSync_q[0], tms};
    tdiSync_d = {tdiSync_q[0], tdi};
  end
  always_ff @(posedge mclk) begin
    tckSync_q <= tckSync_d;
    tmsSync_q <= tmsSync_d;
    tdiSync_q <= tdiSync_d;
  end
  // No reset on the synchronisers; the reset hold flushes them
  // Edges taken from the second and third stages only
  assign tckRise = tckSync_q[1] & ~tckSync_q[2];
  assign tckFall = ~tckSync_q[1] & tckSync_q[2];

  // ****************************************
  // Instruction decode
  // ****************************************
  bstap_decode_t dec;
  bstap_decode uDecode (
    .opcode (instructionLatch),
    .dec    (dec)
  );

  // ****************************************
  // State and registers
  // ****************************************
  bstap_state_t state_q, state_d;
  logic [7:0]   irShift_q, irShift_d, irLatch_q, irLatch_d;
  logic [47:0]  bcShift_q, bcShift_d, bcLatch_q, bcLatch_d;
  logic [2:0]   rsShift_q, rsShift_d, rsLatch_q, rsLatch_d;
  logic [31:0]  idShift_q, idShift_d;
  logic         byShift_q, byShift_d;
  logic         tdo_q, tdo_d, oe_q, oe_d;
  logic         tmsS, tdiS, serialOut;
  logic         inShift, inUpdDr, inUpdIr, inReset;
  logic [47:0]  bcResetMask;

  assign tmsS = tmsSync_q[1];
  assign tdiS = tdiSync_q[1];

  // ****************************************
  // State decode shared by the groups below
  // ****************************************
  // Shared so the TDO and latch groups agree on each state
  assign inShift = (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);
  assign inUpdDr = (state_q == ST_UPD_DR);
  assign inUpdIr = (state_q == ST_UPD_IR);
  assign inReset = (state_q == ST_RESET);

  // Output-enable cells return to one so a later test mode floats the pins
  for (genvar b = 0; b < BCELL_W; b++) begin : g_oeMask
    assign bcResetMask[b] = (b >= OE_CELL_LO) && (b <= OE_CELL_HI);
  end

  // ****************************************
  // Controller state machine
  // ****************************************
  // TMS is taken at the synchronised rise; TCK high and low need three mclk each
  always_comb begin
    state_d = state_q;
    if (tckRise) begin
      case (state_q)
        ST_RESET:    state_d = tmsS ? ST_RESET    : ST_IDLE;
        ST_IDLE:     state_d = tmsS ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_DR:   state_d = tmsS ? ST_SEL_IR   : ST_CAP_DR;
        ST_CAP_DR:   state_d = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: state_d = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: state_d = tmsS ? ST_UPD_DR   : ST_PAUSE_DR;
        ST_PAUSE_DR: state_d = tmsS ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: state_d = tmsS ? ST_UPD_DR   : ST_SHIFT_DR;
        ST_UPD_DR:   state_d = tmsS ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_IR:   state_d = tmsS ? ST_RESET    : ST_CAP_IR;
        ST_CAP_IR:   state_d = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: state_d = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: state_d = tmsS ? ST_UPD_IR   : ST_PAUSE_IR;
        ST_PAUSE_IR: state_d = tmsS ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: state_d = tmsS ? ST_UPD_IR   : ST_SHIFT_IR;
        ST_UPD_IR:   state_d = tmsS ? ST_SEL_DR   : ST_IDLE;
        default:     state_d = ST_RESET;
      endcase
    end
  end

  // ****************************************
  // Shift stages
  // ****************************************
  // Capture and shift on rising edges of TCK
  always_comb begin
    irShift_d = irShift_q;
    bcShift_d = bcShift_q;
    rsShift_d = rsShift_q;
    idShift_d = idShift_q;
    byShift_d = byShift_q;
    if (tckRise) begin
      case (state_q)
        ST_CAP_IR:   irShift_d = IR_CAPTURE;
        ST_SHIFT_IR: irShift_d = {tdiS, irShift_q[7:1]};
        ST_CAP_DR: begin
          case (dec.drSel)
            DR_BCELL:  bcShift_d = bcellCapture;
            DR_RUNSEL: rsShift_d = rsLatch_q;
            DR_IDENT:  idShift_d = ID_VALUE;
            default:   byShift_d = 1'b0;
          endcase
        end
        ST_SHIFT_DR: begin
          case (dec.drSel)
            DR_BCELL:  bcShift_d = {tdiS, bcShift_q[47:1]};
            DR_RUNSEL: rsShift_d = {tdiS, rsShift_q[2:1]};
            DR_IDENT:  idShift_d = {tdiS, idShift_q[31:1]};
            default:   byShift_d = tdiS;
          endcase
        end
        default: ;  // Pause and exit states keep contents
      endcase
    end
  end

  // ****************************************
  // Serial output select
  // ****************************************
  // Unselected registers hold, so a pause never disturbs them
  // Only one register feeds TDO at a time
  always_comb begin
    case (dec.drSel)
      DR_BCELL:  serialOut = bcShift_q[0];
      DR_RUNSEL: serialOut = rsShift_q[0];
      DR_IDENT:  serialOut = idShift_q[0];
      default:   serialOut = byShift_q;
    endcase
  end

  // ****************************************
  // TDO driver
  // ****************************************
  // Driven on the falling edge so the far side gets half a TCK period of setup
  always_comb begin
    tdo_d = tdo_q;
    oe_d  = oe_q;
    if (tckFall) begin
      oe_d = inShift;
      if (state_q == ST_SHIFT_IR) begin
        tdo_d = irShift_q[0];
      end else if (state_q == ST_SHIFT_DR) begin
        tdo_d = serialOut;
      end
    end
    if (inReset) begin
      oe_d = 1'b0;
    end
  end

  // ****************************************
  // Shadow latches
  // ****************************************
  always_comb begin
    irLatch_d = irLatch_q;
    bcLatch_d = bcLatch_q;
    rsLatch_d = rsLatch_q;
    if (tckFall) begin
      if (inUpdIr) begin
        irLatch_d = irShift_q;
      end
      // Bypass and identity have no shadow latch
      if (inUpdDr) begin
        if (dec.drSel == DR_BCELL) begin
          bcLatch_d = bcShift_q;
        end
        if (dec.drSel == DR_RUNSEL) begin
          rsLatch_d = rsShift_q;
        end
      end
    end
    // Reloaded every cycle in reset, not only on entry
    if (inReset) begin
      irLatch_d = IR_RESET;
      bcLatch_d = bcLatch_d | bcResetMask;
      rsLatch_d = RUNSEL_RESET;
    end
  end

  // ****************************************
  // Registers, one block per group
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irShift_q <= IR_RESET;
      bcShift_q <= '0;
      rsShift_q <= RUNSEL_RESET;
      idShift_q <= '0;
      byShift_q <= 1'b0;
    end else begin
      irShift_q <= irShift_d;
      bcShift_q <= bcShift_d;
      rsShift_q <= rsShift_d;
      idShift_q <= idShift_d;
      byShift_q <= byShift_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irLatch_q <= IR_RESET;
      bcLatch_q <= {4'hF, 44'h0};
      rsLatch_q <= RUNSEL_RESET;
    end else begin
      irLatch_q <= irLatch_d;
      bcLatch_q <= bcLatch_d;
      rsLatch_q <= rsLatch_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      oe_q  <= oe_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tdoOut            = tdo_q;
  assign tdoOe             = oe_q;
  assign boundaryCellChain = bcLatch_q;
  assign runTestOpSelector = rsLatch_q;
  assign instructionLatch  = irLatch_q;
  assign tapState          = state_q;
  // Reset state forces normal function regardless of instruction
  assign testMode          = dec.testMode && (state_q != ST_RESET);
  assign runTestActive     = dec.runTest && (state_q == ST_IDLE);
endmodule : bstap_tap
`default_nettype wire

/* File: tb/bstap_tap_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************************************
// Port-level checks on the TAP block
// ********************************************
module bstap_tap_asserts (
  input wire logic                    mclk,              // System clock
  input wire logic                    sys_rst,           // Sync reset
  input wire logic                    tdoOe,             // TDO enable
  input wire logic [47:0]             boundaryCellChain, // Boundary shadows
  input wire logic [2:0]              runTestOpSelector, // Selector shadow
  input wire logic [7:0]              instructionLatch,  // Instruction
  input wire logic                    runTestActive,     // Run-test busy
  input wire bstap_pkg::bstap_state_t tapState           // Controller state
);
  import bstap_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Reload lands one clock after entry, so only a held reset state is judged
  sequence held_reset_s;
    (tapState == ST_RESET) [*2];
  endsequence
  reset_reload_a: assert property (held_reset_s |-> instructionLatch == 8'h81
    && boundaryCellChain[47:44] == 4'hF && runTestOpSelector == 3'h2)
    else $error("reset state values wrong");
  oe_in_shift_a: assert property (tdoOe |-> tapState inside
    {ST_SHIFT_DR, ST_SHIFT_IR, ST_EXIT1_DR, ST_EXIT1_IR}) else $error("TDO driven off path");
  oe_rise_a: assert property ($rose(tdoOe) |-> tapState inside {ST_SHIFT_DR, ST_SHIFT_IR})
    else $error("TDO enabled outside shift");
  oe_fall_a: assert property ($fell(tdoOe) |-> tapState inside {ST_EXIT1_DR, ST_EXIT1_IR})
    else $error("TDO released outside exit-1");
  run_idle_a: assert property (runTestActive |-> tapState == ST_IDLE)
    else $error("run-test op outside idle");
  latch_update_a: assert property ($changed(instructionLatch) |-> tapState inside
    {ST_UPD_IR, ST_RESET}) else $error("instruction changed outside update");
  sel_update_a: assert property ($changed(runTestOpSelector) |-> tapState inside
    {ST_UPD_DR, ST_RESET}) else $error("selector changed outside update");
  sel_exit_a: assert property ($changed(tapState) && $past(tapState) == ST_SEL_DR
    |-> tapState inside {ST_CAP_DR, ST_SEL_IR}) else $error("bad exit from select");
endmodule : bstap_tap_asserts
`default_nettype wire

/* File: tb/bstap_partner.sv */
`timescale 1ns/100ps
`default_nettype none
// ********************************************
// External test controller model
// ********************************************
module bstap_partner (
  output logic      tck,    // Test clock, parked low between frames
  output logic      tms,    // Mode select
  output logic      tdi,    // Serial data
  input  wire logic tdoOut, // Device TDO level
  input  wire logic tdoOe   // Device TDO enable
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One 160 ns period; TDO is taken just before the rising edge
  task automatic step(input logic m, input logic d, output logic qv, output logic ov);
    tms = m;
    tdi = d;
    #80;
    qv = tdoOe ? tdoOut : 1'bz;
    ov = tdoOe;
    tck = 1'b1;
    #80;
    tck = 1'b0;
    tdi = 1'b1; // Pull-up level once the bit is taken
  endtask : step
endmodule : bstap_partner
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bstap_pkg::*;
  logic         mclk, sys_rst, tck, tms, tdi, tdoOut, tdoOe, testMode, runTestActive, q, oe;
  logic [47:0]  bcellCapture, boundaryCellChain, got;
  logic [2:0]   runTestOpSelector;
  logic [7:0]   instructionLatch;
  bstap_state_t tapState;
  int           fail_count, total_checks;
  logic [7:0]   ops [5] = '{8'hFF, 8'h01, 8'h05, 8'h00, 8'h82};
  bstap_tap i_bstap_tap (.mclk, .sys_rst, .tck, .tms, .tdi, .tdoOut, .tdoOe, .bcellCapture,
    .boundaryCellChain, .runTestOpSelector, .instructionLatch, .testMode, .runTestActive,
    .tapState);
  bstap_partner i_bstap_partner (.tck, .tms, .tdi, .tdoOut, .tdoOe);
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  // ********************************************
  // Access tasks
  // ********************************************
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] seen);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic walk(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++) i_bstap_partner.step(seq[i], 1'b1, q, oe);
  endtask : walk
  // From idle to idle; pauseAt < 0 means no pause in mid-scan
  task automatic scan(input bit ir, input int n, input logic [47:0] din, input int pauseAt,
                      output logic [47:0] dout);
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      i_bstap_partner.step(i == n - 1 || i == pauseAt, din[i], q, oe);
      dout[i] = q;
      chk("tdo enable", 1'b1, oe);
      if (i == pauseAt) walk(8'h04, 4);
    end
    i_bstap_partner.step(1'b1, 1'b1, q, oe);
    chk("tdo release", 1'b0, oe);
    walk(8'h00, 1);
  endtask : scan
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // ********************************************
  // Test sequence
  // ********************************************
  initial begin
    sys_rst = 1'b1;
    bcellCapture = 48'hA5C3_0F96_E17B;
    fail_count = 0;
    total_checks = 0;
    repeat (12) @(posedge mclk);
    @(negedge mclk) sys_rst <= 1'b0;
    @(negedge mclk);
    chk("state", ST_RESET, tapState);
    chk("latch", 8'h81, instructionLatch);
    chk("cells", 4'hF, boundaryCellChain[47:44]);
    chk("selector", 3'h2, runTestOpSelector);
    chk("mode", 1'b0, testMode);
    $display("reset values done");
    walk(8'h00, 1);
    scan(1, 8, 48'h81, -1, got);
    chk("ir capture", 8'h81, got);
    scan(0, 32, 48'h0, 10, got);
    chk("identity", ID_VALUE, got);
    $display("identity done");
    for (int k = 0; k < 3; k++) begin
      scan(1, 8, ops[k], -1, got);
      chk("latch", ops[k], instructionLatch);
      scan(0, 2, 48'h1, -1, got);
      chk("bypass", 2'b10, got);
    end
    $display("bypass done");
    scan(1, 8, 8'h0A, -1, got);
    scan(0, 3, 48'h5, -1, got);
    chk("sel capture", 3'h2, got);
    chk("selector", 3'h5, runTestOpSelector);
    scan(1, 8, 8'h09, -1, got);
    chk("run idle", 1'b1, runTestActive);
    walk(8'h01, 1);
    chk("run off", 1'b0, runTestActive);
    walk(8'h7C, 7);
    chk("state", ST_RESET, tapState);
    chk("latch", 8'h81, instructionLatch);
    chk("selector", 3'h2, runTestOpSelector);
    chk("cells", 4'hF, boundaryCellChain[47:44]);
    $display("selector and reset walk done");
    walk(8'h00, 1);
    for (int k = 3; k < 5; k++) begin
      scan(1, 8, ops[k], -1, got);
      chk("mode", k == 3, testMode);
      scan(0, 48, 48'h0123_4567_89AB, -1, got);
      chk("cell capture", bcellCapture, got);
      chk("cell update", 48'h0123_4567_89AB, boundaryCellChain);
    end
    $display("boundary done");
    tally_and_finish();
  end
  initial begin
    repeat (50000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_top
bind bstap_tap bstap_tap_asserts i_bstap_tap_asserts (.mclk, .sys_rst, .tdoOe,
  .boundaryCellChain, .runTestOpSelector, .instructionLatch, .runTestActive, .tapState);
`default_nettype wire
